// File: rtl/qt_regs.vh
// command codes, mode-bit positions and parameter slots of the drawing engine
`ifndef QT_REGS_VH
`define QT_REGS_VH
// command word: opcode in [15:11], drawing-mode bits in [10:0]
`define OP_QCOPY 5'h00
`define OP_QEXP  5'h01
`define OP_QFILL 5'h02
`define OP_TRAPA 5'h08
`define OP_TRAPR 5'h09
`define OP_WLINA 5'h0A
`define OP_WLINR 5'h0B
// drawing-mode bit positions
`define MB_TRANSPARENT_ENABLE 9
`define MB_SOURCE_REPEAT_SELECT 8
`define MB_AREA_SELECT_A 7
`define MB_NET  5
`define MB_EOS  4
`define MB_FST  3
`define MB_LIN  2
`define MB_HALF 1
`define MB_WORK 0
// parameter slots; quads use 0..15, trapezoids 0..1, work lines 0 only
`define PI_SX  0
`define PI_SY  1
`define PI_AH  2
`define PI_AL  3
`define PI_W   4
`define PI_H   5
`define PI_V1  6
`define PI_V2  8
`define PI_V3  10
`define PI_V4  12
`define PI_C0  14
`define PI_C1  15
`define PI_N   0
`define PI_LX  1
// slots each opcode loads, in word order
`define LM_QCOPY 16'h3FFF
`define LM_QEXP  16'hFFFC
`define LM_QFILL 16'h7FC0
`define LM_TRAP  16'h0003
`define LM_WLIN  16'h0001
`endif

// File: rtl/line_walker.v
// line stepper for quad edges, quad spans and polygon segments
`timescale 1ns/10ps
`default_nettype none
module line_walker (
  // clock and reset
  input  wire        clk_i,
  input  wire        resetn_i,
  // control
  input  wire        start_i,
  input  wire        step_i,
  input  wire        four_conn_i,
  // end points
  input  wire [15:0] x0_i,
  input  wire [15:0] y0_i,
  input  wire [15:0] x1_i,
  input  wire [15:0] y1_i,
  // position
  output reg  [15:0] x_o,
  output reg  [15:0] y_o,
  output wire        last_o,
  output reg  [17:0] len_o
);
  reg        [15:0] xe_reg;
  reg        [15:0] ye_reg;
  reg signed [18:0] err_reg;
  reg signed [18:0] dx_reg;
  reg signed [18:0] dy_reg;
  reg               sx_reg;
  reg               sy_reg;
  reg               fc_reg;
  wire signed [17:0] ddx = $signed({{2{x1_i[15]}}, x1_i}) - $signed({{2{x0_i[15]}}, x0_i});
  wire signed [17:0] ddy = $signed({{2{y1_i[15]}}, y1_i}) - $signed({{2{y0_i[15]}}, y0_i});
  wire        [17:0] adx = ddx[17] ? 18'h0 - ddx : ddx;
  wire        [17:0] ady = ddy[17] ? 18'h0 - ddy : ddy;
  wire signed [19:0] e2  = {err_reg, 1'b0};
  wire signed [19:0] dxw = {dx_reg[18], dx_reg};
  wire signed [19:0] dyw = {dy_reg[18], dy_reg};
  // a finished axis never moves; the other is forced so the walk cannot stall
  wire mx  = (x_o != xe_reg) && ((e2 >= dyw) || (y_o == ye_reg));
  wire my  = (y_o != ye_reg) && ((e2 <= dxw) || (x_o == xe_reg));
  wire myo = my && !(fc_reg && mx); // one axis per step gives the 4-connected walk
  assign last_o = (x_o == xe_reg) && (y_o == ye_reg);

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      x_o     <= 16'h0000;
      y_o     <= 16'h0000;
      xe_reg  <= 16'h0000;
      ye_reg  <= 16'h0000;
      err_reg <= 19'h00000;
      dx_reg  <= 19'h00000;
      dy_reg  <= 19'h00000;
      sx_reg  <= 1'b0;
      sy_reg  <= 1'b0;
      fc_reg  <= 1'b0;
      len_o   <= 18'h00000;
    end else if (start_i) begin
      x_o     <= x0_i;
      y_o     <= y0_i;
      xe_reg  <= x1_i;
      ye_reg  <= y1_i;
      dx_reg  <= {1'b0, adx};
      dy_reg  <= 19'h00000 - {1'b0, ady};
      err_reg <= {1'b0, adx} - {1'b0, ady};
      sx_reg  <= ~ddx[17];
      sy_reg  <= ~ddy[17];
      fc_reg  <= four_conn_i;
      len_o   <= four_conn_i ? adx + ady : ((adx > ady) ? adx : ady);
    end else if (step_i) begin
      if (mx)
        x_o <= sx_reg ? x_o + 16'h0001 : x_o - 16'h0001;
      if (myo)
        y_o <= sy_reg ? y_o + 16'h0001 : y_o - 16'h0001;
      err_reg <= err_reg + (mx ? dy_reg : 19'h00000) + (myo ? dx_reg : 19'h00000);
    end
  end
endmodule // line_walker
`default_nettype wire

// File: rtl/quad_trap_engine.v
// quad, trapezoid and work-plane polyline command engine
`timescale 1ns/10ps
`default_nettype none
`include "qt_regs.vh"
module quad_trap_engine (
  // clock and reset
  input  wire         clk_i,
  input  wire         resetn_i,
  // display list words
  input  wire         list_valid_i,
  input  wire [15:0]  list_word_i,
  output reg          list_ready_o,
  // mode, status and current pointer
  input  wire         pix8_i,
  input  wire         cp_set_i,
  input  wire [15:0]  cp_x_i,
  input  wire [15:0]  cp_y_i,
  output reg          busy_o,
  output reg  [15:0]  cp_x_o,
  output reg  [15:0]  cp_y_o,
  // area_select_a rectangles, inclusive, signed
  input  wire [15:0]  sys_xmin_i,
  input  wire [15:0]  sys_ymin_i,
  input  wire [15:0]  sys_xmax_i,
  input  wire [15:0]  sys_ymax_i,
  input  wire [15:0]  usr_xmin_i,
  input  wire [15:0]  usr_ymin_i,
  input  wire [15:0]  usr_xmax_i,
  input  wire [15:0]  usr_ymax_i,
  // source group fetch
  output reg          src_req_o,
  output reg          src_linear_o,
  output reg  [31:0]  src_addr_o,
  output reg  [15:0]  src_x_o,
  output reg  [15:0]  src_y_o,
  input  wire         src_ack_i,
  input  wire [127:0] src_group_i,
  // work-plane read, address on pix_x_o/pix_y_o
  output reg          wrk_rd_req_o,
  input  wire         wrk_rd_ack_i,
  input  wire         wrk_rd_bit_i,
  // pixel write
  output reg          pix_req_o,
  output reg          pix_work_o,
  output reg          pix_xor_o,
  output reg  [15:0]  pix_x_o,
  output reg  [15:0]  pix_y_o,
  output reg  [15:0]  pix_data_o,
  input  wire         pix_ack_i
);
  localparam S_IDLE = 5'd0, S_LOAD = 5'd1, S_GO = 5'd2, S_QSTART = 5'd3, S_QSPAN = 5'd4;
  localparam S_QPIX = 5'd5, S_QFETCH = 5'd6, S_QWORK = 5'd7, S_QEMIT = 5'd8, S_WRITE = 5'd9;
  localparam S_QNEXT = 5'd10, S_CCATCH = 5'd11, S_RCATCH = 5'd12, S_VX = 5'd13, S_VY = 5'd14;
  localparam S_SEG = 5'd15, S_LPIX = 5'd16, S_LNEXT = 5'd17, S_TROW = 5'd18, S_TPIX = 5'd19;
  localparam S_TADV = 5'd20, S_TSKIP = 5'd21, S_SEGEND = 5'd22;

  reg  [4:0]   state_reg;
  reg  [4:0]   ret_reg;
  reg  [4:0]   op_reg;
  reg  [10:0]  mode_reg;
  reg  [15:0]  mask_reg;
  reg  [3:0]   idx_reg;
  reg  [15:0]  prm [0:15];
  reg  [15:0]  row_reg;
  reg  [15:0]  col_reg;
  reg  [19:0]  racc_reg;
  reg  [19:0]  cacc_reg;
  reg  [127:0] grp_reg;
  reg  [28:0]  gtag_reg;
  reg          grp_ok_reg;
  reg  [15:0]  vn_reg;
  reg          first_reg;
  reg  [15:0]  px_reg;
  reg  [15:0]  py_reg;
  reg  [15:0]  nx_reg;
  reg  [15:0]  ny_reg;
  reg  [15:0]  ybot_reg;
  reg  [15:0]  tx_reg;
  reg  [15:0]  ty_reg;
  integer      i;

  wire [15:0] w     = list_word_i;
  wire        take  = list_ready_o & list_valid_i;
  wire        rel   = op_reg[0];
  wire        quad  = (op_reg[4:2] == 3'b000);
  wire        trap  = (op_reg == `OP_TRAPA) | (op_reg == `OP_TRAPR);
  wire        parity_select   = mode_reg[`MB_EOS];
  wire        source_repeat_select  = mode_reg[`MB_SOURCE_REPEAT_SELECT];
  wire [15:0] wid   = (op_reg == `OP_QFILL) ? 16'h0000 : prm[`PI_W];
  wire [15:0] hgt   = (op_reg == `OP_QFILL) ? 16'h0000 : prm[`PI_H];
  wire        swap  = trap & ($signed(ny_reg) < $signed(py_reg));

  // edges v1->v4 and v2->v3, spans between them, segments for polygons
  wire [15:0] el_x, el_y, er_x, er_y, ws_x, ws_y;
  wire [17:0] el_len, er_len, ws_len;
  wire        el_last, er_last, ws_last;
  wire        q_start  = (state_reg == S_QSTART);
  wire        el_step  = (state_reg == S_QNEXT) & ws_last & ~el_last;
  wire        er_step  = (state_reg == S_QNEXT) & ws_last & ~er_last;
  wire        ws_start = (state_reg == S_QSPAN) | (state_reg == S_SEG);
  wire        ws_step  = ~ws_last & ((state_reg == S_QNEXT) | (state_reg == S_LNEXT) |
                                     (state_reg == S_TADV));
  wire [15:0] sg_x0 = quad ? el_x : (swap ? nx_reg : px_reg);
  wire [15:0] sg_y0 = quad ? el_y : (swap ? ny_reg : py_reg);
  wire [15:0] sg_x1 = quad ? er_x : (swap ? px_reg : nx_reg);
  wire [15:0] sg_y1 = quad ? er_y : (swap ? py_reg : ny_reg);

  line_walker u_edge_l (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(q_start),
    .step_i(el_step), .four_conn_i(1'b0), .x0_i(prm[`PI_V1]), .y0_i(prm[`PI_V1+1]),
    .x1_i(prm[`PI_V4]), .y1_i(prm[`PI_V4+1]), .x_o(el_x), .y_o(el_y), .last_o(el_last),
    .len_o(el_len));
  line_walker u_edge_r (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(q_start),
    .step_i(er_step), .four_conn_i(1'b0), .x0_i(prm[`PI_V2]), .y0_i(prm[`PI_V2+1]),
    .x1_i(prm[`PI_V3]), .y1_i(prm[`PI_V3+1]), .x_o(er_x), .y_o(er_y), .last_o(er_last),
    .len_o(er_len));
  // quad spans walk 4-connected so diagonal spans leave no holes
  line_walker u_seg (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(ws_start),
    .step_i(ws_step), .four_conn_i(quad), .x0_i(sg_x0), .y0_i(sg_y0), .x1_i(sg_x1),
    .y1_i(sg_y1), .x_o(ws_x), .y_o(ws_y), .last_o(ws_last), .len_o(ws_len));

  // scale denominators: pixels in this span, spans in this quad
  wire [19:0] cden = {2'b00, ws_len} + 20'h00001;
  wire [19:0] rden = {2'b00, ((el_len > er_len) ? el_len : er_len)} + 20'h00001;

  // source side: half select samples every other column, parity chooses which
  wire        half  = (op_reg == `OP_QEXP) & mode_reg[`MB_HALF];
  wire [15:0] scol  = half ? {col_reg[14:0], parity_select} : col_reg;
  wire [28:0] tag   = {row_reg, scol[15:3]};
  wire [31:0] prod  = {16'h0000, row_reg} * {16'h0000, wid};
  wire        lin   = (op_reg == `OP_QEXP) | (mode_reg[`MB_LIN] & pix8_i);
  wire [15:0] lane  = grp_reg[{scol[2:0], 4'h0} +: 16];
  wire        sbit  = grp_reg[scol[2:0]];
  wire [15:0] pv    = (op_reg == `OP_QCOPY) ? lane :
                      ((op_reg == `OP_QEXP) & sbit) ? prm[`PI_C1] : prm[`PI_C0];
  wire [15:0] pv8   = pix8_i ? {8'h00, pv[7:0]} : pv;
  wire        transparent_enable  = mode_reg[`MB_TRANSPARENT_ENABLE] &
                      (((op_reg == `OP_QEXP) & ~sbit) | ((op_reg == `OP_QCOPY) & (pv8 == 16'h0000)));

  // area_select_a and net test on the point about to be written
  wire [15:0] pt_x  = trap ? tx_reg : ws_x;
  wire [15:0] pt_y  = trap ? ty_reg : ws_y;
  wire        ua    = mode_reg[`MB_AREA_SELECT_A];
  wire        area_select_a_ok = ($signed(pt_x) >= $signed(ua ? usr_xmin_i : sys_xmin_i)) &
                        ($signed(pt_x) <= $signed(ua ? usr_xmax_i : sys_xmax_i)) &
                        ($signed(pt_y) >= $signed(ua ? usr_ymin_i : sys_ymin_i)) &
                        ($signed(pt_y) <= $signed(ua ? usr_ymax_i : sys_ymax_i));
  wire        net_skip = mode_reg[`MB_NET] & ((pt_x[0] ^ pt_y[0]) != parity_select);
  wire        emit_ok  = area_select_a_ok & ~net_skip & ~transparent_enable;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= S_IDLE;   ret_reg <= S_IDLE;    op_reg <= 5'h00;
      mode_reg <= 11'h000;   mask_reg <= 16'h0000; idx_reg <= 4'h0;
      for (i = 0; i < 16; i = i + 1)
        prm[i] <= 16'h0000;
      row_reg <= 16'h0000;   col_reg <= 16'h0000;  racc_reg <= 20'h00000;
      cacc_reg <= 20'h00000; grp_reg <= 128'h0;    gtag_reg <= 29'h0;
      grp_ok_reg <= 1'b0;    vn_reg <= 16'h0000;   first_reg <= 1'b0;
      px_reg <= 16'h0000;    py_reg <= 16'h0000;   nx_reg <= 16'h0000;
      ny_reg <= 16'h0000;    ybot_reg <= 16'h0000; tx_reg <= 16'h0000;
      ty_reg <= 16'h0000;    list_ready_o <= 1'b0; busy_o <= 1'b0;
      cp_x_o <= 16'h0000;    cp_y_o <= 16'h0000;   src_req_o <= 1'b0;
      src_linear_o <= 1'b0;  src_addr_o <= 32'h0;  src_x_o <= 16'h0000;
      src_y_o <= 16'h0000;   wrk_rd_req_o <= 1'b0; pix_req_o <= 1'b0;
      pix_work_o <= 1'b0;    pix_xor_o <= 1'b0;    pix_x_o <= 16'h0000;
      pix_y_o <= 16'h0000;   pix_data_o <= 16'h0000;
    end else begin
      busy_o <= (state_reg != S_IDLE);
      case (state_reg)
        S_IDLE: begin
          if (cp_set_i) begin
            cp_x_o <= cp_x_i;
            cp_y_o <= cp_y_i;
          end
          if (take) begin
            list_ready_o <= 1'b0;
            op_reg       <= w[15:11];
            mode_reg     <= w[10:0];
            idx_reg      <= 4'h0;
            state_reg    <= S_LOAD;
            case (w[15:11])
              `OP_QCOPY: mask_reg <= `LM_QCOPY;
              `OP_QEXP:  mask_reg <= `LM_QEXP;
              `OP_QFILL: mask_reg <= `LM_QFILL;
              `OP_TRAPA, `OP_TRAPR: mask_reg <= `LM_TRAP;
              `OP_WLINA, `OP_WLINR: mask_reg <= `LM_WLIN;
              // other codes belong to other blocks; the word is dropped
              default: state_reg <= S_IDLE;
            endcase
          end else
            list_ready_o <= 1'b1;
        end
        S_LOAD: begin
          if (!mask_reg[idx_reg])
            idx_reg <= idx_reg + 4'h1;
          else if (take) begin
            list_ready_o  <= 1'b0;
            prm[idx_reg]  <= w;
            idx_reg       <= idx_reg + 4'h1;
            if ((mask_reg >> idx_reg) == 16'h0001)
              state_reg <= S_GO;
          end else
            list_ready_o <= 1'b1;
        end
        S_GO: begin
          if (quad) begin
            row_reg    <= 16'h0000;
            racc_reg   <= 20'h00000;
            grp_ok_reg <= 1'b0;
            state_reg  <= S_QSTART;
          end else begin
            vn_reg    <= prm[`PI_N];
            first_reg <= ~rel;
            px_reg    <= cp_x_o;
            py_reg    <= cp_y_o;
            state_reg <= (prm[`PI_N] == 16'h0000) ? S_IDLE : S_VX;
          end
        end
        S_QSTART: state_reg <= S_QSPAN;
        S_QSPAN: begin
          col_reg   <= 16'h0000;
          cacc_reg  <= 20'h00000;
          state_reg <= S_QPIX;
        end
        S_QPIX: begin
          if ((op_reg != `OP_QFILL) && (!grp_ok_reg || (gtag_reg != tag))) begin
            src_req_o    <= 1'b1;
            src_linear_o <= lin;
            src_addr_o   <= {prm[`PI_AH], prm[`PI_AL]} + prod + {16'h0000, scol[15:3], 3'b000};
            src_x_o      <= prm[`PI_SX] + {scol[15:3], 3'b000};
            src_y_o      <= prm[`PI_SY] + row_reg;
            state_reg    <= S_QFETCH;
          end else if (mode_reg[`MB_WORK]) begin
            wrk_rd_req_o <= 1'b1;
            pix_x_o      <= ws_x;
            pix_y_o      <= ws_y;
            state_reg    <= S_QWORK;
          end else
            state_reg <= S_QEMIT;
        end
        S_QFETCH: if (src_ack_i) begin
          src_req_o  <= 1'b0;
          grp_reg    <= src_group_i;
          gtag_reg   <= tag;
          grp_ok_reg <= 1'b1;
          state_reg  <= S_QPIX;
        end
        S_QWORK: if (wrk_rd_ack_i) begin
          wrk_rd_req_o <= 1'b0;
          state_reg    <= wrk_rd_bit_i ? S_QEMIT : S_QNEXT;
        end
        S_QEMIT: begin
          state_reg <= S_QNEXT;
          if (emit_ok) begin
            pix_req_o  <= 1'b1;
            pix_work_o <= 1'b0;
            pix_xor_o  <= 1'b0;
            pix_x_o    <= ws_x;
            pix_y_o    <= ws_y;
            pix_data_o <= pv8;
            ret_reg    <= S_QNEXT;
            state_reg  <= S_WRITE;
          end
        end
        S_WRITE: if (pix_ack_i) begin
          pix_req_o <= 1'b0;
          state_reg <= ret_reg;
        end
        S_QNEXT: begin
          if (ws_last) begin
            if (el_last & er_last)
              state_reg <= S_IDLE;
            else if (source_repeat_select) begin
              row_reg   <= (row_reg + 16'h0001 >= hgt) ? 16'h0000 : row_reg + 16'h0001;
              state_reg <= S_QSPAN;
            end else begin
              racc_reg  <= racc_reg + {4'h0, hgt};
              state_reg <= S_RCATCH;
            end
          end else if (source_repeat_select) begin
            col_reg   <= (col_reg + 16'h0001 >= wid) ? 16'h0000 : col_reg + 16'h0001;
            state_reg <= S_QPIX;
          end else begin
            cacc_reg  <= cacc_reg + {4'h0, wid};
            state_reg <= S_CCATCH;
          end
        end
        // one subtraction per cycle: large shrink ratios cost extra cycles, no divider
        S_CCATCH: begin
          if (cacc_reg >= cden) begin
            cacc_reg <= cacc_reg - cden;
            col_reg  <= col_reg + 16'h0001;
          end else
            state_reg <= S_QPIX;
        end
        S_RCATCH: begin
          if (racc_reg >= rden) begin
            racc_reg <= racc_reg - rden;
            row_reg  <= row_reg + 16'h0001;
          end else
            state_reg <= S_QSPAN;
        end
        S_VX: if (take) begin
          list_ready_o <= 1'b0;
          nx_reg       <= rel ? px_reg + w : w;
          state_reg    <= S_VY;
        end else
          list_ready_o <= 1'b1;
        S_VY: if (take) begin
          list_ready_o <= 1'b0;
          ny_reg       <= rel ? py_reg + w : w;
          vn_reg       <= vn_reg - 16'h0001;
          if (first_reg) begin
            first_reg <= 1'b0;
            px_reg    <= nx_reg;
            py_reg    <= w;
            state_reg <= (vn_reg == 16'h0001) ? S_IDLE : S_VX;
          end else begin
            ybot_reg  <= ($signed(w) > $signed(py_reg)) ? w : py_reg;
            state_reg <= S_SEG;
          end
        end else
          list_ready_o <= 1'b1;
        S_SEG: begin
          if (rel)
            ybot_reg <= ($signed(ny_reg) > $signed(py_reg)) ? ny_reg : py_reg;
          state_reg <= trap ? S_TROW : S_LPIX;
        end
        S_LPIX: begin
          state_reg <= S_LNEXT;
          if (area_select_a_ok) begin
            pix_req_o  <= 1'b1;
            pix_work_o <= 1'b1;
            pix_xor_o  <= 1'b0;
            pix_x_o    <= ws_x;
            pix_y_o    <= ws_y;
            pix_data_o <= {15'h0000, parity_select};
            ret_reg    <= S_LNEXT;
            state_reg  <= S_WRITE;
          end
        end
        S_LNEXT: state_reg <= ws_last ? S_SEGEND : S_LPIX;
        S_TROW: begin
          if (ws_y == ybot_reg)
            state_reg <= S_SEGEND;
          else begin
            ty_reg    <= ws_y;
            tx_reg    <= prm[`PI_LX];
            state_reg <= S_TPIX;
          end
        end
        S_TPIX: begin
          if ($signed(tx_reg) > $signed(ws_x))
            state_reg <= S_TADV;
          else begin
            tx_reg <= tx_reg + 16'h0001;
            if (area_select_a_ok) begin
              pix_req_o  <= 1'b1;
              pix_work_o <= 1'b1;
              pix_xor_o  <= 1'b1;
              pix_x_o    <= tx_reg;
              pix_y_o    <= ty_reg;
              pix_data_o <= 16'h0001;
              ret_reg    <= S_TPIX;
              state_reg  <= S_WRITE;
            end
          end
        end
        S_TADV: state_reg <= ws_last ? S_SEGEND : S_TSKIP;
        // only the first point reached on a row bounds that row's span
        S_TSKIP: state_reg <= (ws_y == ty_reg) ? S_TADV : S_TROW;
        S_SEGEND: begin
          px_reg <= nx_reg;
          py_reg <= ny_reg;
          if (vn_reg == 16'h0000) begin
            if (rel) begin
              cp_x_o <= nx_reg;
              cp_y_o <= ny_reg;
            end
            state_reg <= S_IDLE;
          end else
            state_reg <= S_VX;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // quad_trap_engine
`default_nettype wire

// File: test/qt_properties.sv
// checker of handshake and pixel-write relations of the drawing engine
`timescale 1ns/10ps
`default_nettype none
module qt_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        resetn_i,
  // list, mode and source
  input wire logic        list_valid_i,
  input wire logic        list_ready_o,
  input wire logic        pix8_i,
  input wire logic        src_req_o,
  input wire logic [31:0] src_addr_o,
  input wire logic        src_ack_i,
  // work read and pixel write
  input wire logic        wrk_rd_req_o,
  input wire logic        wrk_rd_ack_i,
  input wire logic        pix_req_o,
  input wire logic        pix_work_o,
  input wire logic        pix_xor_o,
  input wire logic [15:0] pix_x_o,
  input wire logic [15:0] pix_y_o,
  input wire logic [15:0] pix_data_o,
  input wire logic        pix_ack_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence word_taken; list_valid_i && list_ready_o; endsequence
  sequence pix_pending; pix_req_o && !pix_ack_i; endsequence
  list_gap_a: assert property (word_taken |=> !list_ready_o)
    else $error("ready stayed high after a word was taken");
  pix_hold_a: assert property (pix_pending |=> pix_req_o && $stable({pix_x_o, pix_y_o, pix_data_o}))
    else $error("pixel request changed before ack");
  pix_drop_a: assert property (pix_req_o && pix_ack_i |=> !pix_req_o)
    else $error("pixel request not released after ack");
  src_hold_a: assert property (src_req_o && !src_ack_i |=> src_req_o && $stable(src_addr_o))
    else $error("source request changed before ack");
  src_drop_a: assert property (src_ack_i |=> !src_req_o)
    else $error("source request not released after ack");
  work_hold_a: assert property (wrk_rd_req_o && !wrk_rd_ack_i |=> wrk_rd_req_o && $stable(pix_x_o))
    else $error("work read changed before ack");
  xor_work_a: assert property (pix_req_o && pix_xor_o |-> pix_work_o && pix_data_o[0])
    else $error("exclusive-or write not a work-plane one");
  byte_zero_a: assert property (pix8_i && pix_req_o && !pix_work_o |-> pix_data_o[15:8] == 8'h00)
    else $error("upper byte set in 8-bit mode");
endmodule // qt_checker
bind quad_trap_engine qt_checker chk_u (.clk_i, .resetn_i, .list_valid_i, .list_ready_o, .pix8_i,
  .src_req_o, .src_addr_o, .src_ack_i, .wrk_rd_req_o, .wrk_rd_ack_i, .pix_req_o, .pix_work_o,
  .pix_xor_o, .pix_x_o, .pix_y_o, .pix_data_o, .pix_ack_i);
`default_nettype wire

// File: test/mem_model.sv
// memory-side model answering source, work-plane and pixel requests
`timescale 1ns/10ps
`default_nettype none
module mem_model (
  // clock and test controls
  input  wire logic         clk_i,
  input  wire logic         slow_i,
  input  wire logic         wbit_i,
  input  wire logic         clr_i,
  // requests
  input  wire logic         src_req_i,
  input  wire logic         wrk_req_i,
  input  wire logic         pix_req_i,
  input  wire logic         pix_work_i,
  input  wire logic [15:0]  pix_x_i,
  input  wire logic [15:0]  pix_y_i,
  input  wire logic [15:0]  pix_data_i,
  // answers
  output var  logic         src_ack_o,
  output wire logic [127:0] src_group_o,
  output var  logic         wrk_ack_o,
  output wire logic         wrk_bit_o,
  output var  logic         pix_ack_o
);
  // upper byte set so that 8-bit mode has to clear it
  localparam logic [127:0] GROUP = {8{16'hA5FF}};
  logic [1:0]  wait_reg;
  logic [15:0] cnt_w, cnt_r, max_y, last_x, last_d;
  // off-ack cycles carry the inverse so a stale sample cannot pass
  assign src_group_o = src_ack_o ? GROUP : ~GROUP;
  assign wrk_bit_o = wrk_ack_o ? wbit_i : ~wbit_i;
  always @(posedge clk_i) begin
    src_ack_o <= src_req_i && !src_ack_o;
    wrk_ack_o <= wrk_req_i && !wrk_ack_o;
    pix_ack_o <= 1'b0;
    if (clr_i) begin
      {cnt_w, cnt_r, max_y, wait_reg} <= '0;
    end else if (pix_req_i && !pix_ack_o) begin
      // slow mode holds each write three cycles longer
      wait_reg <= (wait_reg == {slow_i, slow_i}) ? 2'h0 : wait_reg + 2'h1;
      if (wait_reg == {slow_i, slow_i}) begin
        pix_ack_o <= 1'b1;
        last_x <= pix_x_i;
        last_d <= pix_data_i;
        cnt_w <= cnt_w + {15'h0, pix_work_i};
        cnt_r <= cnt_r + {15'h0, !pix_work_i};
        if (pix_work_i && pix_y_i > max_y) max_y <= pix_y_i;
      end
    end
  end
endmodule // mem_model
`default_nettype wire

// File: test/quad_trap_engine_test.sv
// testbench of the quad, trapezoid and work-polyline engine
`timescale 1ns/10ps
`default_nettype none
module quad_trap_engine_test;
  logic clk_i = 0, resetn_i = 0, list_valid_i = 0, pix8_i = 0, cp_set_i = 0;
  logic slow = 0, wbit = 0, clr = 1;
  logic [15:0] sys_xmax = 16'h0004, usr_xmin = 16'h00C8;
  logic [15:0] list_word_i = 16'h0000, cp_x_i = 16'h0000, cp_y_i = 16'h0000, mode = 16'h0000;
  wire logic list_ready_o, busy_o, src_req_o, src_ack_i, wrk_rd_req_o, wrk_rd_ack_i, wrk_rd_bit_i;
  wire logic pix_req_o, pix_work_o, pix_xor_o, pix_ack_i, src_linear_o;
  wire logic [15:0] cp_x_o, cp_y_o, pix_x_o, pix_y_o, pix_data_o, src_x_o, src_y_o;
  wire logic [31:0] src_addr_o;
  wire logic [127:0] src_group_i;
  int error_cnt = 0, checks = 0;
  always #50 clk_i = ~clk_i;
  quad_trap_engine dut_u (.clk_i, .resetn_i, .list_valid_i, .list_word_i, .list_ready_o, .pix8_i,
    .cp_set_i, .cp_x_i, .cp_y_i, .busy_o, .cp_x_o, .cp_y_o, .sys_xmin_i(16'h0000),
    .sys_ymin_i(16'h0000), .sys_xmax_i(sys_xmax), .sys_ymax_i(16'h0064), .usr_xmin_i(usr_xmin),
    .usr_ymin_i(16'h00C8), .usr_xmax_i(cp_x_i | 16'h0100), .usr_ymax_i(16'h012C), .src_req_o,
    .src_linear_o, .src_addr_o, .src_x_o, .src_y_o, .src_ack_i, .src_group_i,
    .wrk_rd_req_o, .wrk_rd_ack_i, .wrk_rd_bit_i, .pix_req_o, .pix_work_o, .pix_xor_o, .pix_x_o,
    .pix_y_o, .pix_data_o, .pix_ack_i);
  mem_model mem_u (.clk_i, .slow_i(slow), .wbit_i(wbit), .clr_i(clr), .src_req_i(src_req_o),
    .wrk_req_i(wrk_rd_req_o), .pix_req_i(pix_req_o), .pix_work_i(pix_work_o), .pix_x_i(pix_x_o),
    .pix_y_i(pix_y_o), .pix_data_i(pix_data_o), .src_ack_o(src_ack_i), .src_group_o(src_group_i),
    .wrk_ack_o(wrk_rd_ack_i), .wrk_bit_o(wrk_rd_bit_i), .pix_ack_o(pix_ack_i));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // sends one whole command, then waits for the engine to go idle
  task automatic run(input logic [15:0] w[$]);
    clr <= 1'b1;
    foreach (w[i]) begin
      list_valid_i <= 1'b1;
      list_word_i <= w[i];
      do @(negedge clk_i); while (list_ready_o !== 1'b1);
      @(posedge clk_i);
      clr <= 1'b0;
    end
    list_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (int k = 0; k < 3000 && busy_o !== 1'b0; k++) @(negedge clk_i);
    if (busy_o !== 1'b0) begin
      error_cnt++;
      $display("wrong value at %0t: engine never went idle", $time);
      report_and_stop();
    end
    @(posedge clk_i);
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    run('{16'h5010, 16'h0002, 16'h0002, 16'h0003, 16'h0005, 16'h0003});
    check(mem_u.cnt_w, 16'h0003);
    check(mem_u.last_x, 16'h0004);
    check({15'h0, mem_u.last_d[0]}, 16'h0001);
    cp_x_i <= 16'h000A;
    cp_y_i <= 16'h000A;
    cp_set_i <= 1'b1;
    sys_xmax <= 16'h0064;
    slow <= 1'b1;
    @(posedge clk_i);
    cp_set_i <= 1'b0;
    run('{16'h5800, 16'h0001, 16'h0003, 16'h0003});
    check(mem_u.cnt_w, 16'h0004);
    check({15'h0, mem_u.last_d[0]}, 16'h0000);
    check(cp_x_o, 16'h000D);
    run('{16'h4000, 16'h0002, 16'h0000, 16'h0002, 16'h0000, 16'h0002, 16'h0002});
    check(mem_u.cnt_w, 16'h0006);
    check(mem_u.max_y, 16'h0001);
    run('{16'h4800, 16'h0001, 16'h000D, 16'h0000, 16'h0002});
    check(mem_u.cnt_w, 16'h0002);
    check(cp_y_o, 16'h000F);
    slow <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      mode <= 16'h1000 | (i == 3 ? 16'h0080 : {15'h0, i[0] ^ i[1]});
      wbit <= i[1];
      @(posedge clk_i);
      run('{mode, 16'h0004, 16'h0004, 16'h0005, 16'h0004, 16'h0005, 16'h0005, 16'h0004,
        16'h0005, 16'h1234});
      check({15'h0, mem_u.cnt_r != 16'h0000}, {15'h0, !i[0]});
    end
    check(mem_u.last_d, 16'h1234);
    pix8_i <= 1'b1;
    // second pass sets linear source addressing
    for (int k = 0; k < 2; k++) begin
      run('{k ? 16'h0004 : 16'h0000, 16'h0003, 16'h0007, 16'h0001, 16'h0020, 16'h0008,
        16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000});
      check(mem_u.last_d, 16'h00FF);
      check({15'h0, src_linear_o}, {15'h0, k[0]});
      check(src_addr_o[31:16], 16'h0001);
      check(src_addr_o[15:0], 16'h0020);
      check(src_x_o, 16'h0003);
      check(src_y_o, 16'h0007);
    end
    pix8_i <= 1'b0;
    run('{16'h0800, 16'h0000, 16'h0000, 16'h0008, 16'h0001, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0011, 16'h0022});
    check(mem_u.last_d, 16'h0022);
    report_and_stop();
  end
endmodule // quad_trap_engine_test
`default_nettype wire
